// ==== rtl/lsw_pkg.sv ====
`default_nettype none
package lsw_pkg;
  // serial word
  localparam int          WORD_W      = 16;
  localparam int          ADDR_MSB    = 15;
  localparam int          ADDR_LSB    = 8;
  localparam int          DATA_MSB    = 7;
  localparam int          DATA_LSB    = 0;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  // synchroniser bit order {clk, cs_n, din}
  localparam int          SER_CLK_BIT = 2;
  localparam int          SER_CS_BIT  = 1;
  localparam int          SER_DIN_BIT = 0;
  localparam logic [2:0]  SER_IDLE    = 3'h2;
  // display geometry
  localparam int          FULL_DIGITS = 8;
  localparam int          SEG_W       = 8;
  localparam int          LINES       = 8;
  localparam int          DIGIT_W     = 3;
  localparam logic [2:0]  DIGIT_FIRST = 3'h0;
  localparam logic [2:0]  DIGIT_STEP  = 3'h1;
  // segment byte: bit 7 dp, 6 a, 5 b, 4 c, 3 d, 2 e, 1 f, 0 g
  localparam int          SEG_A_BIT   = 6;
  // segment bit carried by the n-th free shared line: dp g f e d c b
  localparam logic [2:0]  SEG_OF_POS [0:6] =
    '{3'h7, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  localparam logic [7:0]  LINES_OFF   = 8'hff;
  localparam logic [7:0]  LINES_LOW   = 8'h00;
  // internal multiplex oscillator stand-in
  localparam int          SYS_CLK_HZ  = 100_000_000;
  localparam int          INT_OSC_HZ  = 4_000_000;
  localparam int          INT_OSC_DIV = SYS_CLK_HZ / INT_OSC_HZ;
endpackage : lsw_pkg
`default_nettype wire

// ==== rtl/lsw_map_if.sv ====
`default_nettype none
interface lsw_map_if;
  logic [2:0] digit;
  logic [7:0] segs;
  logic       enable;
  logic [7:0] lines_out;
  logic [7:0] lines_oe_n;
  logic       seg_a_out;
  logic       seg_a_oe_n;
  modport scan (output digit, segs, enable,
                input  lines_out, lines_oe_n, seg_a_out, seg_a_oe_n);
  modport map  (input  digit, segs, enable,
                output lines_out, lines_oe_n, seg_a_out, seg_a_oe_n);
endinterface : lsw_map_if
`default_nettype wire

// ==== rtl/lsw_line_map.sv ====
`default_nettype none
module lsw_line_map (
  // scan side
  lsw_map_if.map m
);
  always_comb begin
    logic [2:0] pos;
    logic [2:0] bit_sel;
    pos = 3'h0;
    bit_sel = 3'h0;
    m.lines_out  = lsw_pkg::LINES_LOW;
    m.lines_oe_n = lsw_pkg::LINES_OFF;
    m.seg_a_out  = 1'b0;
    m.seg_a_oe_n = 1'b1;
    if (m.enable) begin
      for (int j = 0; j < lsw_pkg::LINES; j++) begin
        if (3'(j) == m.digit) begin
          // digit_common_cathode sinks on its own line
          m.lines_oe_n[j] = 1'b0;
        end else begin
          // free lines carry dp g f e d c b in order
          pos = (3'(j) < m.digit) ? 3'(j) : 3'(j - 1);
          bit_sel = lsw_pkg::SEG_OF_POS[pos];
          if (m.segs[bit_sel]) begin
            m.lines_out[j]  = 1'b1;
            m.lines_oe_n[j] = 1'b0;
          end
        end
      end
      // segment a always on the segment-only line
      if (m.segs[lsw_pkg::SEG_A_BIT]) begin
        m.seg_a_out  = 1'b1;
        m.seg_a_oe_n = 1'b0;
      end
    end
  end // anything not driven stays released
endmodule : lsw_line_map
`default_nettype wire

// ==== rtl/lsw_serial_write_port.sv ====
`default_nettype none
// Operation
// - shift din on each serial clock rise
// - no shifting while chip select high
// - chip select rise latches last sixteen bits
// - word: upper byte address, lower byte data
// - serial clock may idle low or high
// - three input-only wires: clock, select, data
// - undriven lines are high impedance
// - own digit sinks, others source segments
// - eight LEDs per digit, eight or five digits
// - reduced variant: upper three digits stay dark
// - cathode on line k, a on ninth line
// - odd bit counts keep last sixteen bits
// - no read path back to host
module lsw_serial_write_port #(
  parameter int NUM_DIGITS = lsw_pkg::FULL_DIGITS,
  parameter int OSC_DIV    = lsw_pkg::INT_OSC_DIV
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // serial write port, inputs only
  input  wire logic        ser_clk,
  input  wire logic        ser_cs_n,
  input  wire logic        ser_din,
  // multiplex clock
  input  wire logic        mux_clock_in,
  input  wire logic        use_ext_mux_clk,
  // scan setup from local logic
  input  wire logic [2:0]  scan_limit,
  input  wire logic [63:0] digit_segments,
  // received command
  output logic      [7:0]  cmd_addr,
  output logic      [7:0]  cmd_data,
  output logic             cmd_strobe,
  // display lines
  output logic      [7:0]  shared_cathode_segment_line_out,
  output logic      [7:0]  shared_cathode_segment_line_oe_n,
  output logic             segment_only_line_out,
  output logic             segment_only_line_oe_n
);
  localparam int OSC_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;

  typedef struct packed {
    logic [2:0]       ser_s1;
    logic [2:0]       ser_s2;
    logic             clk_prev;
    logic             cs_prev;
    logic [15:0]      shift;
    logic [15:0]      cmd;
    logic             cmd_stb;
    logic [1:0]       mux_s1;
    logic [1:0]       mux_s2;
    logic             mux_prev;
    logic [OSC_W-1:0] osc_cnt;
    logic [2:0]       digit;
    logic [7:0]       line_out;
    logic [7:0]       line_oe_n;
    logic             seg_a_out;
    logic             seg_a_oe_n;
  } lsw_state_t;

  localparam lsw_state_t STATE_RESET = '{
    ser_s1:     lsw_pkg::SER_IDLE,
    ser_s2:     lsw_pkg::SER_IDLE,
    clk_prev:   1'b0,
    cs_prev:    1'b1,
    shift:      lsw_pkg::WORD_RESET,
    cmd:        lsw_pkg::WORD_RESET,
    cmd_stb:    1'b0,
    mux_s1:     2'h0,
    mux_s2:     2'h0,
    mux_prev:   1'b0,
    osc_cnt:    '0,
    digit:      lsw_pkg::DIGIT_FIRST,
    line_out:   lsw_pkg::LINES_LOW,
    line_oe_n:  lsw_pkg::LINES_OFF,
    seg_a_out:  1'b0,
    seg_a_oe_n: 1'b1
  };

  lsw_state_t q_reg;
  lsw_state_t q_next;
  logic       clk_rise;
  logic       cs_rise;
  logic       mux_tick;

  lsw_map_if map_bus ();

  lsw_line_map u_map (
    .m (map_bus.map)
  );

  // mapper sees the digit being scanned now
  assign map_bus.digit  = q_reg.digit;
  assign map_bus.segs   = digit_segments[q_reg.digit*lsw_pkg::SEG_W +:
                                         lsw_pkg::SEG_W];
  assign map_bus.enable = int'(q_reg.digit) < NUM_DIGITS;

  // edges found on second-stage samples only
  assign clk_rise = q_reg.ser_s2[lsw_pkg::SER_CLK_BIT] & ~q_reg.clk_prev;
  assign cs_rise  = q_reg.ser_s2[lsw_pkg::SER_CS_BIT] & ~q_reg.cs_prev;

  always_comb begin
    q_next = q_reg;
    q_next.ser_s1 = {ser_clk, ser_cs_n, ser_din};
    q_next.ser_s2 = q_reg.ser_s1;
    q_next.clk_prev = q_reg.ser_s2[lsw_pkg::SER_CLK_BIT];
    q_next.cs_prev  = q_reg.ser_s2[lsw_pkg::SER_CS_BIT];
    q_next.cmd_stb  = 1'b0;
    // only rising edges count, so either idle level is harmless
    if (clk_rise && !q_reg.ser_s2[lsw_pkg::SER_CS_BIT]) begin
      q_next.shift = {q_reg.shift[lsw_pkg::WORD_W-2:0],
                      q_reg.ser_s2[lsw_pkg::SER_DIN_BIT]};
    end
    // shift register clears only on reset: stale bits fill short words
    if (cs_rise) begin
      q_next.cmd     = q_reg.shift;
      q_next.cmd_stb = 1'b1;
    end
    q_next.mux_s1   = {use_ext_mux_clk, mux_clock_in};
    q_next.mux_s2   = q_reg.mux_s1;
    q_next.mux_prev = q_reg.mux_s2[0];
    q_next.osc_cnt  = (q_reg.osc_cnt == '0) ? OSC_W'(OSC_DIV - 1)
                                            : q_reg.osc_cnt - OSC_W'(1);
    if (mux_tick) begin
      q_next.digit = (q_reg.digit >= scan_limit) ? lsw_pkg::DIGIT_FIRST
                     : q_reg.digit + lsw_pkg::DIGIT_STEP;
    end
    q_next.line_out   = map_bus.lines_out;
    q_next.line_oe_n  = map_bus.lines_oe_n;
    q_next.seg_a_out  = map_bus.seg_a_out;
    q_next.seg_a_oe_n = map_bus.seg_a_oe_n;
  end

  // external clock is slow against sys_clk, so edge sampling is safe
  assign mux_tick = q_reg.mux_s2[1] ? (q_reg.mux_s2[0] & ~q_reg.mux_prev)
                                    : (q_reg.osc_cnt == '0);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q_reg <= STATE_RESET;
    end else begin
      q_reg <= q_next;
    end
  end

  // no serial output exists at all
  assign cmd_addr   = q_reg.cmd[lsw_pkg::ADDR_MSB:lsw_pkg::ADDR_LSB];
  assign cmd_data   = q_reg.cmd[lsw_pkg::DATA_MSB:lsw_pkg::DATA_LSB];
  assign cmd_strobe = q_reg.cmd_stb;
  assign shared_cathode_segment_line_out  = q_reg.line_out;
  assign shared_cathode_segment_line_oe_n = q_reg.line_oe_n;
  assign segment_only_line_out            = q_reg.seg_a_out;
  assign segment_only_line_oe_n           = q_reg.seg_a_oe_n;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_shift_on_edge: assert property (
    clk_rise && !q_reg.ser_s2[lsw_pkg::SER_CS_BIT] |=>
      q_reg.shift == {$past(q_reg.shift[14:0]),
                      $past(q_reg.ser_s2[lsw_pkg::SER_DIN_BIT])})
    else $error("bit not shifted on serial clock rise");
  chk_hold_cs_high: assert property (
    q_reg.ser_s2[lsw_pkg::SER_CS_BIT] |=> $stable(q_reg.shift))
    else $error("shift register moved while deselected");
  chk_latch_cs_rise: assert property (
    cs_rise |=> cmd_strobe && {cmd_addr, cmd_data} == $past(q_reg.shift))
    else $error("command word not latched on select rise");
  chk_strobe_only_rise: assert property (
    cmd_strobe |-> $past(cs_rise) ##1 !cmd_strobe)
    else $error("command strobe without select rise");
  chk_one_cathode: assert property (
    $onehot0(~shared_cathode_segment_line_out &
             ~shared_cathode_segment_line_oe_n))
    else $error("more than one cathode sinking");
  chk_own_cathode: assert property (
    !$past(rst) && int'($past(q_reg.digit)) < NUM_DIGITS |->
      !shared_cathode_segment_line_oe_n[$past(q_reg.digit)] &&
      !shared_cathode_segment_line_out[$past(q_reg.digit)])
    else $error("scanned digit cathode not sinking");
  chk_dark_digits: assert property (
    !$past(rst) && int'($past(q_reg.digit)) >= NUM_DIGITS |->
      &shared_cathode_segment_line_oe_n && segment_only_line_oe_n)
    else $error("missing digit drives a line");
  chk_seg_a_line: assert property (
    !$past(rst) && int'($past(q_reg.digit)) < NUM_DIGITS |->
      segment_only_line_oe_n == !$past(map_bus.segs[lsw_pkg::SEG_A_BIT]))
    else $error("segment a line wrong");
  chk_scan_wrap: assert property (
    mux_tick && q_reg.digit >= scan_limit |=> q_reg.digit == 3'h0)
    else $error("scan did not wrap at limit");
  chk_scan_step: assert property (
    mux_tick && q_reg.digit < scan_limit |=>
      q_reg.digit == $past(q_reg.digit) + 3'h1)
    else $error("scan did not step");

  // latched word must survive stray clocks between frames
  chk_cmd_hold: assert property (
    !cs_rise |=> $stable(q_reg.cmd))
    else $error("command word changed without select rise");
  chk_shift_kept: assert property (
    cs_rise |=> $stable(q_reg.shift))
    else $error("shift register cleared by latch");
  chk_reset_dark: assert property (
    $past(rst) |-> &shared_cathode_segment_line_oe_n &&
      segment_only_line_oe_n)
    else $error("line driven straight after reset");

  cov_cmd_latched: cover property (cs_rise ##1 cmd_strobe);
  cov_scan_wrap: cover property (mux_tick && q_reg.digit == scan_limit);
  cov_seg_lit: cover property (!segment_only_line_oe_n);
  cov_dark_digit: cover property (int'(q_reg.digit) >= NUM_DIGITS);
  cov_int_tick: cover property (!q_reg.mux_s2[1] && mux_tick);
endmodule : lsw_serial_write_port
`default_nettype wire

// ==== tb/lsw_host_model.sv ====
`default_nettype none
module lsw_host_model (
  // serial pins toward the port
  output var logic ser_clk,
  output var logic ser_cs_n,
  output var logic ser_din
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    ser_clk  = 1'b0;
    ser_cs_n = 1'b1;
    ser_din  = 1'b0;
  end

  // sel low keeps select high, so the clock burst must be ignored
  task automatic frame(input logic [31:0] w, input int n,
                       input logic idle, input logic sel);
    ser_clk = idle;
    #125;
    ser_cs_n = ~sel;
    #125;
    for (int i = n - 1; i >= 0; i--) begin
      ser_clk = 1'b0;
      ser_din = w[i];
      #62.5;
      ser_clk = 1'b1;
      #62.5;
    end
    ser_clk = idle;
    #62.5;
    ser_cs_n = 1'b1;
    // released data line must not keep its last value
    ser_din = ~ser_din;
    #125;
  endtask : frame
endmodule : lsw_host_model
`default_nettype wire

// ==== tb/lsw_serial_write_port_test.sv ====
`default_nettype none
module lsw_serial_write_port_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk;
  logic        rst;
  logic        ser_clk;
  logic        ser_cs_n;
  logic        ser_din;
  logic        mux_clock_in;
  logic [2:0]  scan_limit;
  logic [63:0] digit_segments;
  logic [7:0]  cmd_addr;
  logic [7:0]  cmd_data;
  logic        cmd_strobe;
  logic [7:0]  line_out;
  logic [7:0]  line_oe_n;
  logic        seg_a;
  logic        seg_a_oe_n;
  logic        use_ext;
  logic [7:0]  r_line_out;
  logic [7:0]  r_line_oe_n;
  logic        r_seg_a;
  logic        r_seg_a_oe_n;

  localparam int OSC_DIV_TB     = 4;
  localparam int REDUCED_DIGITS = 5;
  logic [31:0] seed;
  logic [15:0] exp_sr;
  int          strobes;
  int          bad_count;
  int          n_compared;

  lsw_host_model lsw_host_model_i (
    .ser_clk  (ser_clk),
    .ser_cs_n (ser_cs_n),
    .ser_din  (ser_din)
  );

  lsw_serial_write_port #(
    .NUM_DIGITS(lsw_pkg::FULL_DIGITS),
    .OSC_DIV   (OSC_DIV_TB)
  ) lsw_serial_write_port_i (
    .sys_clk                         (sys_clk),
    .rst                             (rst),
    .ser_clk                         (ser_clk),
    .ser_cs_n                        (ser_cs_n),
    .ser_din                         (ser_din),
    .mux_clock_in                    (mux_clock_in),
    .use_ext_mux_clk                 (use_ext),
    .scan_limit                      (scan_limit),
    .digit_segments                  (digit_segments),
    .cmd_addr                        (cmd_addr),
    .cmd_data                        (cmd_data),
    .cmd_strobe                      (cmd_strobe),
    .shared_cathode_segment_line_out (line_out),
    .shared_cathode_segment_line_oe_n(line_oe_n),
    .segment_only_line_out           (seg_a),
    .segment_only_line_oe_n          (seg_a_oe_n)
  );

  // reduced variant sees the same stimulus and steps the same digits
  if (1) begin : reduced
    lsw_serial_write_port #(
      .NUM_DIGITS(REDUCED_DIGITS),
      .OSC_DIV   (OSC_DIV_TB)
    ) lsw_serial_write_port_i (
      .sys_clk                         (sys_clk),
      .rst                             (rst),
      .ser_clk                         (ser_clk),
      .ser_cs_n                        (ser_cs_n),
      .ser_din                         (ser_din),
      .mux_clock_in                    (mux_clock_in),
      .use_ext_mux_clk                 (use_ext),
      .scan_limit                      (scan_limit),
      .digit_segments                  (digit_segments),
      .cmd_addr                        (),
      .cmd_data                        (),
      .cmd_strobe                      (),
      .shared_cathode_segment_line_out (r_line_out),
      .shared_cathode_segment_line_oe_n(r_line_oe_n),
      .segment_only_line_out           (r_seg_a),
      .segment_only_line_oe_n          (r_seg_a_oe_n)
    );
  end

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // 4 mhz external scan clock, free running, edges off sys_clk rises
  initial begin
    mux_clock_in = 1'b0;
    #1;
    forever #125 mux_clock_in = ~mux_clock_in;
  end

  always @(posedge sys_clk) if (cmd_strobe === 1'b1) strobes++;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [17:0] exp_lines(input int k, input logic [7:0] s);
    logic [7:0] oe;
    logic [7:0] o;
    int         p;
    oe    = 8'hff;
    o     = 8'h00;
    oe[k] = 1'b0;
    p     = 0;
    for (int l = 0; l < 8; l++) if (l != k) begin
      if (s[lsw_pkg::SEG_OF_POS[p]]) begin
        oe[l] = 1'b0;
        o[l]  = 1'b1;
      end
      p++;
    end
    return {oe, o, ~s[lsw_pkg::SEG_A_BIT], s[lsw_pkg::SEG_A_BIT]};
  endfunction : exp_lines

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic results();
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic send(input int n, input logic sel);
    logic [31:0] w;
    int          c0;
    w  = rnd();
    c0 = strobes;
    lsw_host_model_i.frame(w, n, w[31], sel);
    if (sel) for (int b = n - 1; b >= 0; b--) exp_sr = {exp_sr[14:0], w[b]};
    chk("strobe", 32'(strobes - c0), {31'h0, sel});
    chk("addr", {24'h0, cmd_addr}, {24'h0, exp_sr[15:8]});
    chk("data", {24'h0, cmd_data}, {24'h0, exp_sr[7:0]});
  endtask : send

  task automatic scan(input logic [2:0] lim, input logic ext);
    int          k;
    int          prev;
    logic [7:0]  sk;
    logic [17:0] ex;
    @(negedge sys_clk);
    use_ext        = ext;
    scan_limit     = lim;
    digit_segments = {rnd(), rnd()};
    repeat (2) @(negedge mux_clock_in);
    prev = -1;
    repeat (20) begin
      // internal divider steps once per OSC_DIV_TB cycles
      if (ext) begin
        @(negedge mux_clock_in);
        @(negedge sys_clk);
      end else begin
        repeat (OSC_DIV_TB) @(negedge sys_clk);
      end
      sk = ~line_oe_n & ~line_out;
      chk("sinks", 32'($countones(sk)), 32'h1);
      k = 0;
      for (int i = 0; i < 8; i++) if (sk[i]) k = i;
      if (prev >= 0) begin
        chk("digit", 32'(k), 32'((prev >= lim) ? 0 : prev + 1));
      end
      ex = exp_lines(k, digit_segments[8*k+:8]);
      chk("lines", 32'({line_oe_n, line_out & ~line_oe_n, seg_a_oe_n,
          seg_a & ~seg_a_oe_n}), 32'(ex));
      if (k >= REDUCED_DIGITS) ex = {8'hff, 8'h00, 2'h2};
      chk("reduced", 32'({r_line_oe_n, r_line_out & ~r_line_oe_n,
          r_seg_a_oe_n, r_seg_a & ~r_seg_a_oe_n}), 32'(ex));
      prev = k;
    end
  endtask : scan

  // whole run is roughly 46 us
  initial begin
    #500us;
    bad_count++;
    results();
  end

  initial begin
    seed           = 32'hf43a;
    exp_sr         = lsw_pkg::WORD_RESET;
    strobes        = 0;
    bad_count      = 0;
    n_compared     = 0;
    rst            = 1'b1;
    use_ext        = 1'b1;
    scan_limit     = 3'h7;
    digit_segments = 64'h0;
    repeat (3) @(negedge sys_clk);
    chk("oe_rst", {24'h0, line_oe_n}, 32'hff);
    rst = 1'b0;
    // odd offset keeps serial edges clear of sys_clk rises
    #101;
    for (int i = 0; i < 12; i++) begin
      send((i == 4) ? 8 : (i == 7) ? 20 : (i == 10) ? 0 : 16,
           (i != 2) && (i != 9));
    end
    scan(3'h0, 1'b1);
    scan(3'h7, 1'b1);
    scan(3'h7, 1'b0);
    scan(3'(rnd()), 1'b0);
    scan(3'(rnd()), 1'b1);
    results();
  end
endmodule : lsw_serial_write_port_test
`default_nettype wire
